// >>> rtl/partition_id_virtualizer.sv
// partition identifier virtualizer: registers, access checks and request labelling
`timescale 1ns/1ns
`default_nettype none
module partition_id_virtualizer
	import piv_pkg::*;
#(
	parameter logic [2:0]  COUNT_MAX = 3'h7,    // mapping_register_count_max
	parameter logic [15:0] PART_MAX  = 16'h00FF, // largest_partition_value
	parameter logic        VIRT_SUP  = 1'b1     // virtualization_supported
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire pivEl_t      curEl,      // current privilege level
	input  wire logic        el2Enabled, // level two present and enabled here
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wrStrobe,
	input  wire logic        rdStrobe,
	output logic      [31:0] rdata,
	output logic             trapToEl2,  // pulse: access trapped to level two
	output logic             trapToEl3,  // pulse: access trapped to level three
	output logic             undefAcc,   // pulse: access undefined
	output pivLabel_t        reqLabel    // physical ids for outgoing requests
);

	localparam int WORDS = 2 * (int'(COUNT_MAX) + 1); // two entries per bus word
	localparam int WA    = $clog2(WORDS);

	////////////////////////////////////////////////////////////////////////////////
	// control registers
	logic [31:0] hypCtl_q;   // hyp_partition_control
	logic [31:0] valid_q;    // mapping_valid_bits
	logic [31:0] appReg_q;   // app_level_partition_register
	logic [31:0] guestReg_q; // guest_level_partition_register
	logic [31:0] hypReg_q;   // hyp_level_partition_register
	logic [31:0] monReg_q;   // monitor_level_partition_register
	logic [31:0] hypCfg_q;   // hyp_config_register

	logic        hostBit;    // host_in_level_two
	logic        lowerTrap;  // lower_level_trap
	logic        virtOn;     // virtualization available in this state
	logic [4:0]  maxIdx;     // largest usable virtual identifier

	assign hostBit   = hypCfg_q[HCFG_HOST];
	assign lowerTrap = hypCfg_q[HCFG_LOWER];
	assign virtOn    = el2Enabled & VIRT_SUP;
	assign maxIdx    = {COUNT_MAX, 2'b11};    // four per register plus three

	////////////////////////////////////////////////////////////////////////////////
	// access decode: which register an access reaches and whether it faults
	pivTarget_t tgt;
	pivFault_t  flt;
	logic       mapInRange;
	logic [7:0] mapOfs;

	assign mapOfs     = addr - OFS_MAP_BASE;
	assign mapInRange = (addr >= OFS_MAP_BASE) && (int'(mapOfs[7:2]) < WORDS);

	// lower-level trap to three outranks every level-two trap
	always_comb
	begin
		tgt = TGT_NONE;
		flt = FLT_NONE;
		case (addr)
			OFS_CAP_ID:
			begin
				tgt = TGT_CAP;
				if (curEl == EL0)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl != EL3)
					flt = FLT_TRAP3;
				else if (curEl == EL1 && virtOn && hypCtl_q[HCTL_IDTRAP])
					flt = FLT_TRAP2;
			end
			OFS_HYP_CTL, OFS_VALID:
			begin
				tgt = (addr == OFS_HYP_CTL) ? TGT_HCTL : TGT_VALID;
				if (curEl < EL2)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl == EL2)
					flt = FLT_TRAP3;
			end
			OFS_APP:
			begin
				// host bit plays no part here
				tgt = TGT_APP;
				if (curEl == EL0)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl != EL3)
					flt = FLT_TRAP3;
			end
			OFS_GUEST:
			begin
				tgt = (curEl == EL2 && hostBit) ? TGT_HYP : TGT_GUEST;
				if (curEl == EL0)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl != EL3)
					flt = FLT_TRAP3;
				else if (curEl == EL1 && hypCtl_q[HCTL_GTRAP])
					flt = FLT_TRAP2;
			end
			OFS_HYP:
			begin
				tgt = TGT_HYP;
				if (curEl < EL2)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl == EL2)
					flt = FLT_TRAP3;
			end
			OFS_MON:
			begin
				tgt = TGT_MON;
				if (curEl != EL3)
					flt = FLT_UNDEF;
			end
			OFS_ALIAS:
			begin
				// alias bypasses the guest register trap
				tgt = TGT_GUEST;
				if (curEl < EL2 || !hostBit)
					flt = FLT_UNDEF;
				else if (lowerTrap && curEl == EL2)
					flt = FLT_TRAP3;
			end
			OFS_HYP_CFG:
			begin
				tgt = TGT_HCFG;
				if (curEl < EL2)
					flt = FLT_UNDEF;
			end
			default:
			begin
				// mapping words are written by levels two and three only
				if (mapInRange && addr[1:0] == 2'b00)
				begin
					tgt = TGT_MAP;
					if (curEl < EL2)
						flt = FLT_UNDEF;
					else if (lowerTrap && curEl == EL2)
						flt = FLT_TRAP3;
				end
			end
		endcase
	end

	logic accOk;  // strobe present and no fault
	logic wrOk;

	assign accOk = (wrStrobe | rdStrobe) && tgt != TGT_NONE && flt == FLT_NONE;
	assign wrOk  = wrStrobe && accOk;

	////////////////////////////////////////////////////////////////////////////////
	// register writes; each takes effect for lookups from the next cycle
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			hypCtl_q   <= RST_HYP_CTL;
			valid_q    <= RST_VALID;
			appReg_q   <= RST_PART;
			guestReg_q <= RST_PART;
			hypReg_q   <= RST_PART;
			monReg_q   <= RST_PART;
			hypCfg_q   <= RST_HYP_CFG;
		end
		else if (wrOk)
		begin
			case (tgt)
				TGT_HCTL:  hypCtl_q   <= wdata;
				TGT_VALID: valid_q    <= wdata;
				TGT_APP:   appReg_q   <= wdata;
				TGT_GUEST: guestReg_q <= wdata;
				TGT_HYP:   hypReg_q   <= wdata;
				TGT_MON:   monReg_q   <= wdata;
				TGT_HCFG:
				begin
					hypCfg_q[HCFG_HOST] <= wdata[HCFG_HOST];
					// only level three may set or clear the lower trap
					if (curEl == EL3)
						hypCfg_q[HCFG_LOWER] <= wdata[HCFG_LOWER];
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault pulses, one cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			trapToEl2 <= 1'b0;
			trapToEl3 <= 1'b0;
			undefAcc  <= 1'b0;
		end
		else
		begin
			trapToEl2 <= (wrStrobe | rdStrobe) && flt == FLT_TRAP2;
			trapToEl3 <= (wrStrobe | rdStrobe) && flt == FLT_TRAP3;
			undefAcc  <= (wrStrobe | rdStrobe) && (flt == FLT_UNDEF || tgt == TGT_NONE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read word for registers held here; faulted reads return zero
	logic [31:0] regWord;

	always_comb
	begin
		regWord = 32'h0000_0000;
		if (rdStrobe && accOk)
		begin
			case (tgt)
				TGT_CAP:
				begin
					regWord                            = {16'h0000, PART_MAX};
					regWord[CAP_CNT_LSB +: 3]          = COUNT_MAX;
					regWord[CAP_VIRT]                  = VIRT_SUP;
				end
				TGT_HCTL:  regWord = hypCtl_q;
				TGT_VALID: regWord = valid_q;
				TGT_APP:   regWord = appReg_q;
				TGT_GUEST: regWord = guestReg_q;
				TGT_HYP:   regWord = hypReg_q;
				TGT_MON:   regWord = monReg_q;
				TGT_HCFG:  regWord = hypCfg_q;
				default:   regWord = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// source selection by privilege level
	logic [31:0] srcReg;
	logic        mapEn;

	always_comb
	begin
		case (curEl)
			EL0:
			begin
				srcReg = hypCtl_q[HCTL_LOCK] ? guestReg_q : appReg_q;
				mapEn  = hypCtl_q[HCTL_LOCK] ? hypCtl_q[HCTL_GUEST_EN] : hypCtl_q[HCTL_APP_EN];
			end
			EL1:
			begin
				srcReg = guestReg_q;
				mapEn  = hypCtl_q[HCTL_GUEST_EN];
			end
			EL2:
			begin
				srcReg = hypReg_q;
				mapEn  = 1'b0;
			end
			default:
			begin
				srcReg = monReg_q;
				mapEn  = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// virtual id resolution, used for both instruction and data ids
	function automatic pivResolve_t resolve(input logic [15:0] vid, input logic [31:0] vbits,
		input logic [4:0] lim);
		pivResolve_t r;
		logic [4:0]  sub;
		r   = '{idx: DEF_VIRT_ID, usePhys: 1'b0};
		// out-of-range ids are replaced by the top entry
		sub = (vid > {11'h000, lim}) ? lim : vid[4:0];
		if (vbits[sub])
			r.idx = sub;
		else if (vbits[DEF_VIRT_ID])
			r.idx = DEF_VIRT_ID;
		else
			r.usePhys = 1'b1;
		return r;
	endfunction : resolve

	pivResolve_t resI;
	pivResolve_t resD;

	assign resI = resolve(srcReg[15:0], valid_q, maxIdx);
	assign resD = resolve(srcReg[31:16], valid_q, maxIdx);

	////////////////////////////////////////////////////////////////////////////////
	// first stage: remember how each lookup must be finished
	logic        mapOn_q;
	pivResolve_t resI_q;
	pivResolve_t resD_q;
	pivLabel_t   raw_q;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			mapOn_q <= 1'b0;
			resI_q  <= '0;
			resD_q  <= '0;
			raw_q   <= '0;
		end
		else
		begin
			mapOn_q <= mapEn & virtOn;
			resI_q  <= resI;
			resD_q  <= resD;
			raw_q   <= srcReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mapping storage; two entries per bus word, even entry in the low half
	logic [31:0] pairI;
	logic [31:0] pairD;

	piv_map_store #(
		.WORDS (WORDS),
		.WIDTH (32)
	) u_store (
		.clock   (clock),
		.wrEn    (wrOk && tgt == TGT_MAP),
		.wrAddr  (mapOfs[WA+1:2]),
		.wrData  (wdata),
		.rdAddrA (resI.idx[WA:1]),
		.rdDataA (pairI),
		.rdAddrB (resD.idx[WA:1]),
		.rdDataB (pairD),
		.busAddr (mapOfs[WA+1:2]),
		.busSel  (rdStrobe && accOk && tgt == TGT_MAP),
		.bypData (regWord),
		.busData (rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// finish a lookup: entry half, default physical, or unmapped id
	function automatic logic [15:0] finish(input logic on, input pivResolve_t r,
		input logic [31:0] pair, input logic [15:0] raw);
		logic [15:0] v;
		if (!on)
			v = raw;
		else if (r.usePhys)
			v = DEF_PHYS_ID;
		else
			v = r.idx[0] ? pair[31:16] : pair[ENTRY_W-1:0];
		return v;
	endfunction : finish

	// output labels, two cycles after the state they reflect
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			reqLabel <= '0;
		end
		else
		begin
			reqLabel.instrId <= finish(mapOn_q, resI_q, pairI, raw_q.instrId);
			reqLabel.dataId  <= finish(mapOn_q, resD_q, pairD, raw_q.dataId);
		end
	end

endmodule : partition_id_virtualizer
`default_nettype wire

// >>> shared/piv_pkg.sv
// constants, types and register map for the partition identifier virtualizer
// Operation
// - virtualization only with level two and support
// - level-one id register reads trap when enabled
// - separate app and guest mapping enables
// - mapping entries written from level two
// - virtual id indexes entries and valid bits
// - valid entry supplies the physical id
// - out of range above four times count plus three
// - substitute in-range id for both lookups
// - invalid entry falls back to default virtual
// - both invalid gives default physical id
// - host bit redirects guest encoding to level two
// - alias reaches guest register, undefined below two
// - guest register traps to two or three
// - app register access ignores host bit
// - level zero source chosen by guest lock
// - four sixteen-bit entries per mapping register
package piv_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register word offsets (byte addresses)
	localparam logic [7:0] OFS_CAP_ID    = 8'h00; // capability_id_register, read only
	localparam logic [7:0] OFS_HYP_CTL   = 8'h04; // hyp_partition_control
	localparam logic [7:0] OFS_VALID     = 8'h08; // mapping_valid_bits
	localparam logic [7:0] OFS_APP       = 8'h0C; // app_level_partition_register
	localparam logic [7:0] OFS_GUEST     = 8'h10; // guest_level_partition_register encoding
	localparam logic [7:0] OFS_HYP       = 8'h14; // hyp_level_partition_register
	localparam logic [7:0] OFS_MON       = 8'h18; // monitor_level_partition_register
	localparam logic [7:0] OFS_ALIAS     = 8'h1C; // guest_register_alias encoding
	localparam logic [7:0] OFS_HYP_CFG   = 8'h20; // hyp_config_register
	localparam logic [7:0] OFS_MAP_BASE  = 8'h40; // mapping_entry_register words, two entries each

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int HCTL_APP_EN   = 0;  // app_mapping_enable
	localparam int HCTL_GUEST_EN = 1;  // guest_mapping_enable
	localparam int HCTL_LOCK     = 4;  // guest_lock
	localparam int HCTL_GTRAP    = 8;  // guest_register_trap
	localparam int HCTL_IDTRAP   = 31; // id_register_trap_enable
	localparam int HCFG_HOST     = 0;  // host_in_level_two
	localparam int HCFG_LOWER    = 1;  // lower_level_trap, level three only
	localparam int CAP_CNT_LSB   = 16; // mapping_register_count_max
	localparam int CAP_VIRT      = 19; // virtualization_supported

	////////////////////////////////////////////////////////////////////////////////
	// reset values and defaults
	localparam logic [31:0] RST_HYP_CTL = 32'h0000_0000;
	localparam logic [31:0] RST_VALID   = 32'h0000_0000;
	localparam logic [31:0] RST_PART    = 32'h0000_0000;
	localparam logic [31:0] RST_HYP_CFG = 32'h0000_0000;
	localparam logic [4:0]  DEF_VIRT_ID = 5'h00;      // default virtual identifier
	localparam logic [15:0] DEF_PHYS_ID = 16'h0000;   // default physical identifier
	localparam int          ENTRY_W     = 16;         // bits per mapping entry
	localparam int          ENTRIES_PER = 4;          // entries per mapping register

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		EL0 = 2'b00,
		EL1 = 2'b01,
		EL2 = 2'b10,
		EL3 = 2'b11
	} pivEl_t;

	typedef enum logic [1:0] {
		FLT_NONE  = 2'b00,
		FLT_TRAP2 = 2'b01,
		FLT_TRAP3 = 2'b10,
		FLT_UNDEF = 2'b11
	} pivFault_t;

	typedef enum logic [3:0] {
		TGT_NONE  = 4'h0,
		TGT_CAP   = 4'h1,
		TGT_HCTL  = 4'h2,
		TGT_VALID = 4'h3,
		TGT_APP   = 4'h4,
		TGT_GUEST = 4'h5,
		TGT_HYP   = 4'h6,
		TGT_MON   = 4'h7,
		TGT_HCFG  = 4'h8,
		TGT_MAP   = 4'h9
	} pivTarget_t;

	// identifiers that label one memory request pair
	typedef struct packed {
		logic [15:0] dataId;
		logic [15:0] instrId;
	} pivLabel_t;

	// result of resolving one virtual identifier
	typedef struct packed {
		logic [4:0] idx;      // entry finally looked up
		logic       usePhys;  // neither entry valid: default physical
	} pivResolve_t;

endpackage : piv_pkg

// >>> rtl/piv_map_store.sv
// mapping entry storage with two lookup ports and one register read port
`timescale 1ns/1ns
`default_nettype none
module piv_map_store #(
	parameter int WORDS = 16,
	parameter int WIDTH = 32
) (
	input  wire logic                     clock,
	input  wire logic                     wrEn,
	input  wire logic [$clog2(WORDS)-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]         wrData,
	input  wire logic [$clog2(WORDS)-1:0] rdAddrA,
	output logic      [WIDTH-1:0]         rdDataA,
	input  wire logic [$clog2(WORDS)-1:0] rdAddrB,
	output logic      [WIDTH-1:0]         rdDataB,
	input  wire logic [$clog2(WORDS)-1:0] busAddr,
	input  wire logic                     busSel,
	input  wire logic [WIDTH-1:0]         bypData,
	output logic      [WIDTH-1:0]         busData
);

	logic [WIDTH-1:0] mem [WORDS]; // contents are undefined until software writes them

	// single write port
	always_ff @(posedge clock)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
	end

	// lookup ports, registered
	always_ff @(posedge clock)
	begin
		rdDataA <= mem[rdAddrA];
		rdDataB <= mem[rdAddrB];
	end

	// bus read word: either a stored word or the register word handed in
	always_ff @(posedge clock)
	begin
		busData <= busSel ? mem[busAddr] : bypData;
	end

endmodule : piv_map_store
`default_nettype wire

// >>> tb/piv_props.sv
// port checker for the partition identifier virtualizer
`timescale 1ns/1ns
`default_nettype none
module piv_props
	import piv_pkg::*;
#(
	parameter logic [2:0] COUNT_MAX = 3'h7
) (
	input wire logic        clock,
	input wire logic        reset,
	input wire pivEl_t      curEl,
	input wire logic        el2Enabled,
	input wire logic [7:0]  addr,
	input wire logic        wrStrobe,
	input wire logic        rdStrobe,
	input wire logic [31:0] rdata,
	input wire logic        trapToEl2,
	input wire logic        trapToEl3,
	input wire logic        undefAcc,
	input wire pivLabel_t   reqLabel
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// first byte address past the implemented mapping words
	localparam logic [8:0] MAP_END = 9'h040 + 9'(8 * (int'(COUNT_MAX) + 1));
	wire logic acc = wrStrobe | rdStrobe;            // any register access
	wire logic flt = trapToEl2 | trapToEl3 | undefAcc; // any refusal

	////////////////////////////////////////////////////////////////////////////////
	one_fault_a: assert property (flt |-> $onehot({trapToEl2, trapToEl3, undefAcc}))
		else $error("more than one fault pulse");
	fault_cause_a: assert property (!acc |=> !flt)
		else $error("fault pulse without an access");
	alias_undef_a: assert property (acc && addr == OFS_ALIAS && curEl <= EL1 |=> undefAcc)
		else $error("alias below level two not undefined");
	map_low_a: assert property (acc && addr >= OFS_MAP_BASE && curEl == EL1 |=> undefAcc)
		else $error("mapping word reachable from level one");
	map_range_a: assert property (acc && 9'(addr) >= MAP_END && curEl >= EL2 |=> undefAcc)
		else $error("mapping word past the count accepted");
	fault_zero_a: assert property (rdStrobe ##1 flt |-> rdata == 32'h0000_0000)
		else $error("refused read returned data");
	trap_two_a: assert property (trapToEl2 |-> $past(curEl) == EL1)
		else $error("trap to level two from a level other than one");
	trap_three_a: assert property (trapToEl3 |-> $past(curEl) != EL3)
		else $error("trap to level three from level three");
	label_hold_a: assert property (
		(!wrStrobe && $stable(curEl) && $stable(el2Enabled))[*3] |=> $stable(reqLabel))
		else $error("label moved with no cause");
	// main scenarios reached
	cover property (trapToEl2);
	cover property (trapToEl3);
	cover property (rdStrobe ##1 !flt);
endmodule : piv_props

bind partition_id_virtualizer piv_props #(.COUNT_MAX(COUNT_MAX)) piv_props_i (
	.clock(clock), .reset(reset), .curEl(curEl), .el2Enabled(el2Enabled), .addr(addr),
	.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata), .trapToEl2(trapToEl2),
	.trapToEl3(trapToEl3), .undefAcc(undefAcc), .reqLabel(reqLabel));
`default_nettype wire

// >>> tb/piv_core_model.sv
// core-side model: privilege level and enable of level two
`timescale 1ns/1ns
`default_nettype none
module piv_core_model
	import piv_pkg::*;
(
	input  wire logic   clock,
	input  wire logic   reset,
	input  wire pivEl_t elCmd,      // level the bench wants next
	input  wire logic   el2Cmd,     // level two enable wanted next
	output pivEl_t      curEl,
	output logic        el2Enabled
);
	// levels change only on an edge, like an exception entry; software
	// leaves a quiet gap around each change so accesses stay ordered
	always_ff @(posedge clock)
	begin
		curEl      <= reset ? EL1 : elCmd;
		el2Enabled <= reset ? 1'b1 : el2Cmd;
	end
endmodule : piv_core_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the partition identifier virtualizer
`timescale 1ns/1ns
`default_nettype none
module tb;
	import piv_pkg::*;
	logic        clock;
	logic        reset;
	pivEl_t      elCmd;
	logic        el2Cmd;
	pivEl_t      curEl;
	logic        el2Enabled;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wrStrobe;
	logic        rdStrobe;
	logic [31:0] rdata;
	logic        trapToEl2;
	logic        trapToEl3;
	logic        undefAcc;
	pivLabel_t   reqLabel;
	logic [31:0] seenData;  // read data caught in its one valid cycle
	int          nFail;
	int          numChecks;

	// two mapping words per register count step keeps the range test short
	partition_id_virtualizer #(.COUNT_MAX(3'h1)) partition_id_virtualizer_i (
		.clock(clock), .reset(reset), .curEl(curEl), .el2Enabled(el2Enabled),
		.addr(addr), .wdata(wdata), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.rdata(rdata), .trapToEl2(trapToEl2), .trapToEl3(trapToEl3),
		.undefAcc(undefAcc), .reqLabel(reqLabel));
	piv_core_model piv_core_model_i (.clock(clock), .reset(reset), .elCmd(elCmd),
		.el2Cmd(el2Cmd), .curEl(curEl), .el2Enabled(el2Enabled));

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic finishTest;
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finishTest

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		numChecks++;
		if (s !== e)
		begin
			nFail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// one strobe, then a gap cycle; fault code is {toTwo, toThree, undefined}
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [2:0] f);
		wrStrobe <= w;
		rdStrobe <= !w;
		addr     <= a;
		wdata    <= d;
		@(posedge clock);
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b0;
		#1;
		seenData = rdata;
		chk("fault", {29'h0, trapToEl2, trapToEl3, undefAcc}, {29'h0, f});
		@(posedge clock);
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 3'b000);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [2:0] f);
		acc(1'b0, a, 32'h0000_0000, f);
		chk("rdata", seenData, e);
	endtask : rd

	task automatic setEl(input pivEl_t e, input logic en);
		elCmd  <= e;
		el2Cmd <= en;
		repeat (2) @(posedge clock);
	endtask : setEl

	// label settles two edges after its cause
	task automatic lbl(input logic [31:0] e);
		repeat (2) @(posedge clock);
		#1;
		chk("label", reqLabel, e);
		@(posedge clock);
	endtask : lbl

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic tRegs;
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CTL, 32'h0000_0003);
		rd(OFS_HYP_CTL, 32'h0000_0003, 3'b000);
		acc(1'b1, OFS_CAP_ID, 32'hFFFF_FFFF, 3'b000);
		rd(OFS_CAP_ID, 32'h0009_00FF, 3'b000);
		rd(8'h24, 32'h0000_0000, 3'b001);
		setEl(EL1, 1'b1);
		rd(OFS_VALID, 32'h0000_0000, 3'b001);
		acc(1'b1, OFS_MAP_BASE, 32'h0000_0001, 3'b001);
	endtask : tRegs

	task automatic tTraps;
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CTL, 32'h8000_0100);
		setEl(EL1, 1'b1);
		rd(OFS_CAP_ID, 32'h0000_0000, 3'b100);
		rd(OFS_GUEST, 32'h0000_0000, 3'b100);
		wr(OFS_APP, 32'h0003_0004);
		rd(OFS_APP, 32'h0003_0004, 3'b000);
		setEl(EL1, 1'b0);
		rd(OFS_CAP_ID, 32'h0009_00FF, 3'b000);
		setEl(EL3, 1'b1);
		wr(OFS_HYP_CFG, 32'h0000_0003);
		setEl(EL1, 1'b1);
		rd(OFS_GUEST, 32'h0000_0000, 3'b010);
		rd(OFS_APP, 32'h0000_0000, 3'b010);
		setEl(EL2, 1'b1);
		rd(OFS_HYP, 32'h0000_0000, 3'b010);
		setEl(EL3, 1'b1);
		wr(OFS_HYP_CFG, 32'h0000_0000);
	endtask : tTraps

	task automatic tHost;
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CTL, 32'h0000_0003);
		wr(OFS_HYP_CFG, 32'h0000_0001);
		wr(OFS_GUEST, 32'h0005_0004);
		rd(OFS_HYP, 32'h0005_0004, 3'b000);
		wr(OFS_ALIAS, 32'h0007_0006);
		lbl(32'h0005_0004);
		setEl(EL3, 1'b1);
		rd(OFS_GUEST, 32'h0007_0006, 3'b000);
		// level three labels pass unmapped even with both enables set
		wr(OFS_MON, 32'h0009_0008);
		rd(OFS_MON, 32'h0009_0008, 3'b000);
		lbl(32'h0009_0008);
		setEl(EL1, 1'b1);
		rd(OFS_ALIAS, 32'h0000_0000, 3'b001);
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CFG, 32'h0000_0000);
		rd(OFS_ALIAS, 32'h0000_0000, 3'b001);
		rd(OFS_GUEST, 32'h0007_0006, 3'b000);
	endtask : tHost

	task automatic tMap;
		setEl(EL2, 1'b1);
		for (int i = 0; i < 4; i++)
			wr(OFS_MAP_BASE + 8'(4 * i), {16'h0101 + 16'(2 * i), 16'h0100 + 16'(2 * i)});
		rd(OFS_MAP_BASE + 8'h04, 32'h0103_0102, 3'b000);
		rd(OFS_MAP_BASE + 8'h10, 32'h0000_0000, 3'b001);
		wr(OFS_VALID, 32'h0000_00F0);
		wr(OFS_HYP_CTL, 32'h0000_0002);
		wr(OFS_GUEST, 32'h0005_0009);
		setEl(EL1, 1'b1);
		lbl(32'h0105_0107);
		wr(OFS_GUEST, 32'h0002_0003);
		lbl(32'h0000_0000);
		setEl(EL2, 1'b1);
		wr(OFS_VALID, 32'h0000_00F1);
		setEl(EL1, 1'b1);
		lbl(32'h0100_0100);
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CTL, 32'h0000_0013);
		wr(OFS_APP, 32'h0006_0004);
		setEl(EL0, 1'b1);
		lbl(32'h0100_0100);
		setEl(EL2, 1'b1);
		wr(OFS_HYP_CTL, 32'h0000_0001);
		setEl(EL0, 1'b1);
		lbl(32'h0106_0104);
		setEl(EL0, 1'b0);
		lbl(32'h0006_0004);
	endtask : tMap

	// reset in mid-run must clear hyp_partition_control and the guest and level-two registers again
	task automatic tReset;
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		setEl(EL2, 1'b1);
		rd(OFS_HYP_CTL, RST_HYP_CTL, 3'b000);
		rd(OFS_GUEST, RST_PART, 3'b000);
		lbl(RST_PART);
	endtask : tReset

	////////////////////////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial
	begin
		#400000;
		nFail++;
		finishTest();
	end

	initial
	begin
		nFail = 0;
		numChecks = 0;
		reset <= 1'b1;
		elCmd <= EL2;
		el2Cmd <= 1'b1;
		addr <= 8'h00;
		wdata <= 32'h0000_0000;
		wrStrobe <= 1'b0;
		rdStrobe <= 1'b0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		tRegs();
		tTraps();
		tHost();
		tMap();
		tReset();
		finishTest();
	end
endmodule : tb
`default_nettype wire
